// File: core/write_latch_and_block_lock.sv
// Command decoder guarding write commands with the write latch and block locks
// Notes on behaviour
// - Incomplete buffer program address aborts and clears the write latch.
// - Chip select rising off a byte boundary aborts with no action.
// - A failed buffer program sets the program error flag.
// - Opcode 06h sets the write latch at chip select rise.
// - Listed program, erase and status write opcodes need the latch.
// - A latch-guarded command with the latch clear is not executed.
// - Opcodes are eight clocks, most significant bit first.
// - Enable, disable and volatile enable are opcode only.
// - Opcode 04h clears the write latch at chip select rise.
// - Opcode 50h makes a latched 01h status write volatile, latch untouched.
// - Volatile permission lapses after the very next status write.
// - Block lock 36h carries three address bytes, no data.
// - Valid block lock sets the block's lock bit, clears latch.
// - Block locks count only when protect select is set.
// - All block lock bits start at one after reset.
// - Block lock is refused unless the write latch is set.
// - Buffer program ignores the low address byte, page from upper bits.
// - Busy shows during a buffer program and clears when done.
// - Buffer program to a protected place clears latch, no program.
// - Each lock bit covers every aligned 4 kB region with the same address bits 19:12, so 16 regions.
`timescale 1ns/100ps
`default_nettype none
module write_latch_and_block_lock
(
    input  wire logic        SYS_CLK_I,
    input  wire logic        RST_I,
    input  wire logic        CS_N_I,
    input  wire logic        SCK_I,
    input  wire logic        SI_I,
    input  wire logic        PROTECT_SELECT_FLAG_I,
    input  wire logic        PROTECT_COMPLEMENT_BIT_I,
    input  wire logic        PROTECT_SIZE_BIT_I,
    input  wire logic        TOP_BOTTOM_BIT_I,
    input  wire logic [2:0]  BLOCK_PROTECT_FIELD_I,
    input  wire logic        PROGRAM_FAIL_I,
    output logic             WRITE_LATCH_FLAG_O,
    output logic             PROGRAM_ERROR_FLAG_O,
    output logic             BUSY_FLAG_O,
    output logic             VOLATILE_WRITE_EN_O,
    output logic             STATUS_WRITE_GO_O,
    output logic             STATUS_WRITE_VOLATILE_O,
    output logic             GUARDED_GO_O,
    output logic [7:0]       GUARDED_OPCODE_O,
    output logic             PROGRAM_START_O,
    output logic [15:0]      PROGRAM_PAGE_O,
    output logic [255:0]     BLOCK_LOCK_O
);
    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_ADDR    = 5'b00010,
        ST_DATA    = 5'b00100,
        ST_IGNORE  = 5'b01000,
        ST_PROGRAM = 5'b10000
    } cmd_state_e;

    typedef struct packed {
        cmd_state_e  state;
        logic [7:0]  opcode;
        logic [23:0] addr;
        logic [1:0]  addr_cnt;
        logic        latch;
        logic        perr;
        logic        busy;
        logic        vol_en;
        logic        sw_go;
        logic        sw_vol;
        logic        g_go;
        logic [7:0]  g_op;
        logic        p_start;
        logic [15:0] p_page;
        logic [6:0]  p_cnt;
        logic [255:0] locks;
    } ctl_state_s;

    ctl_state_s st;
    ctl_state_s next_st;

    logic       frame_start;
    logic       frame_end;
    logic       byte_valid;
    logic [7:0] byte_data;
    logic       on_boundary;

    spi_byte_rx u_rx
    (
        .clk_i         (SYS_CLK_I),
        .rst_i         (RST_I),
        .cs_n_pin_i    (CS_N_I),
        .sck_pin_i     (SCK_I),
        .si_pin_i      (SI_I),
        .frame_start_o (frame_start),
        .frame_end_o   (frame_end),
        .byte_valid_o  (byte_valid),
        .byte_data_o   (byte_data),
        .on_boundary_o (on_boundary)
    );

    function automatic logic needs_latch(input logic [7:0] op);
        unique case (op)
            8'h02, 8'ha2, 8'h32, 8'haf, 8'had, 8'h88, 8'h81, 8'hdb, 8'h20,
            8'h52, 8'hd8, 8'h60, 8'hc7, 8'h9b, 8'h01, 8'h31, 8'h11, 8'h71,
            8'h0a:        needs_latch = 1'b1;
            default:      needs_latch = 1'b0;
        endcase
    endfunction

    function automatic logic is_status_write(input logic [7:0] op);
        is_status_write = (op == wlatch_pkg::OP_STATUS_WR1) ||
                          (op == wlatch_pkg::OP_STATUS_WR2) ||
                          (op == wlatch_pkg::OP_STATUS_WR3) ||
                          (op == wlatch_pkg::OP_STATUS_WR4);
    endfunction

    // Range protection from the block protect field: 128 kB units, 4 kB with the size bit
    function automatic logic range_protected(input logic [23:0] a, input logic cmp,
                                             input logic sz, input logic tb,
                                             input logic [2:0] bp);
        logic [3:0] unit;
        logic [3:0] span;
        logic       hit;
        unit = sz ? a[15:12] : {1'b0, a[19:17]};
        span = (bp == 3'h0) ? 4'h0 : (4'h1 << (bp - 3'h1));
        if (sz)
        begin
            unit = tb ? a[15:12] : ~a[15:12];
        end
        else
        begin
            unit = tb ? {1'b0, a[19:17]} : {1'b0, ~a[19:17]};
        end
        hit = (bp == 3'h7) ? 1'b1 : (unit < span);
        range_protected = hit ^ cmp;
    endfunction

    logic [7:0] blk_idx;
    logic       prot_hit;

    always_comb
    begin
        // One lock bit per 4 kB
        blk_idx = st.addr[19:12];
        prot_hit = PROTECT_SELECT_FLAG_I ? st.locks[blk_idx]
                 : range_protected(st.addr, PROTECT_COMPLEMENT_BIT_I, PROTECT_SIZE_BIT_I,
                                   TOP_BOTTOM_BIT_I, BLOCK_PROTECT_FIELD_I);
    end

    always_comb
    begin
        next_st = st;
        next_st.sw_go = 1'b0;
        next_st.g_go = 1'b0;
        next_st.p_start = 1'b0;
        if (st.busy && PROGRAM_FAIL_I)
        begin
            next_st.perr = 1'b1;
        end
        if (st.state == ST_PROGRAM)
        begin
            if (st.p_cnt == 7'(wlatch_pkg::PROGRAM_CYCLES - 1))
            begin
                next_st.busy = 1'b0;
                next_st.latch = 1'b0;
                next_st.state = ST_IDLE;
            end
            else
            begin
                next_st.p_cnt = st.p_cnt + 7'h1;
            end
        end
        else if (frame_start)
        begin
            next_st.state = ST_IDLE;
            next_st.addr_cnt = '0;
        end
        else if (byte_valid)
        begin
            unique case (st.state)
                ST_IDLE:
                begin
                    next_st.opcode = byte_data;
                    if (byte_data == wlatch_pkg::OP_BLOCK_LOCK ||
                        byte_data == wlatch_pkg::OP_BUF_PROGRAM)
                    begin
                        next_st.state = ST_ADDR;
                    end
                    else if (byte_data == wlatch_pkg::OP_WRITE_ENABLE ||
                             byte_data == wlatch_pkg::OP_WRITE_DISABLE ||
                             byte_data == wlatch_pkg::OP_VOL_ENABLE)
                    begin
                        next_st.state = ST_DATA;
                    end
                    else
                    begin
                        next_st.state = ST_IGNORE;
                    end
                end
                ST_ADDR:
                begin
                    next_st.addr = {st.addr[15:0], byte_data};
                    next_st.addr_cnt = st.addr_cnt + 2'h1;
                    if (st.addr_cnt == 2'(wlatch_pkg::ADDR_BYTES - 1))
                    begin
                        next_st.state = ST_DATA;
                    end
                end
                ST_DATA:
                begin
                    next_st.state = ST_IGNORE;
                end
                default:
                begin
                    next_st.state = ST_IGNORE;
                end
            endcase
        end
        else if (frame_end)
        begin
            next_st.state = ST_IDLE;
            if (!on_boundary)
            begin
                next_st.state = ST_IDLE;
            end
            else if (st.state == ST_DATA)
            begin
                unique case (st.opcode)
                    wlatch_pkg::OP_WRITE_ENABLE:
                    begin
                        next_st.latch = 1'b1;
                    end
                    wlatch_pkg::OP_WRITE_DISABLE:
                    begin
                        next_st.latch = 1'b0;
                    end
                    wlatch_pkg::OP_VOL_ENABLE:
                    begin
                        next_st.vol_en = 1'b1;
                    end
                    wlatch_pkg::OP_BLOCK_LOCK:
                    begin
                        if (st.latch)
                        begin
                            next_st.locks[blk_idx] = 1'b1;
                            next_st.latch = 1'b0;
                        end
                    end
                    default:
                    begin
                        if (st.latch && prot_hit)
                        begin
                            next_st.latch = 1'b0;
                        end
                        else if (st.latch)
                        begin
                            next_st.p_page = st.addr[23:8];
                            next_st.p_start = 1'b1;
                            next_st.p_cnt = '0;
                            next_st.busy = 1'b1;
                            next_st.state = ST_PROGRAM;
                        end
                    end
                endcase
            end
            else if (st.state == ST_ADDR && st.opcode == wlatch_pkg::OP_BUF_PROGRAM)
            begin
                next_st.latch = 1'b0;
            end
            else if (st.state == ST_IGNORE && needs_latch(st.opcode) &&
                     st.opcode != wlatch_pkg::OP_BUF_PROGRAM)
            begin
                if (st.latch)
                begin
                    next_st.g_go = 1'b1;
                    next_st.g_op = st.opcode;
                    if (is_status_write(st.opcode))
                    begin
                        next_st.sw_go = 1'b1;
                        next_st.sw_vol = st.vol_en &&
                                         (st.opcode == wlatch_pkg::OP_STATUS_WR1);
                    end
                end
                // Permission lapses after next status write
                if (is_status_write(st.opcode))
                begin
                    next_st.vol_en = 1'b0;
                end
            end
            next_st.addr_cnt = '0;
        end
        if (RST_I)
        begin
            next_st = '0;
            next_st.state = ST_IDLE;
            next_st.locks = {wlatch_pkg::BLOCK_COUNT{wlatch_pkg::LOCK_RESET}};
        end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        st <= next_st;
    end

    assign WRITE_LATCH_FLAG_O = st.latch;
    assign PROGRAM_ERROR_FLAG_O = st.perr;
    assign BUSY_FLAG_O = st.busy;
    assign VOLATILE_WRITE_EN_O = st.vol_en;
    assign STATUS_WRITE_GO_O = st.sw_go;
    assign STATUS_WRITE_VOLATILE_O = st.sw_vol;
    assign GUARDED_GO_O = st.g_go;
    assign GUARDED_OPCODE_O = st.g_op;
    assign PROGRAM_START_O = st.p_start;
    assign PROGRAM_PAGE_O = st.p_page;
    assign BLOCK_LOCK_O = st.locks;
endmodule
`default_nettype wire

// File: core/wlatch_pkg.sv
// Constants for the write latch and block lock command block
package wlatch_pkg;
    localparam int unsigned SYS_CLK_HZ      = 25000000;
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_VOL_ENABLE    = 8'h50;
    localparam logic [7:0] OP_BLOCK_LOCK    = 8'h36;
    localparam logic [7:0] OP_BUF_PROGRAM   = 8'h88;
    localparam logic [7:0] OP_STATUS_WR1    = 8'h01;
    localparam logic [7:0] OP_STATUS_WR2    = 8'h31;
    localparam logic [7:0] OP_STATUS_WR3    = 8'h11;
    localparam logic [7:0] OP_STATUS_WR4    = 8'h71;
    localparam int unsigned ADDR_BITS       = 24;
    localparam int unsigned ADDR_BYTES      = 3;
    localparam int unsigned PAGE_LSB        = 8;
    localparam int unsigned BLOCK_LSB       = 12;
    localparam int unsigned BLOCK_COUNT     = 256;
    localparam int unsigned BLOCK_IDX_BITS  = 8;
    localparam logic        LOCK_RESET      = 1'b1;
    localparam int unsigned BIT_CNT_BITS    = 3;
    localparam int unsigned BYTE_CNT_BITS   = 2;
    localparam int unsigned PROGRAM_CYCLES  = 64;
    localparam int unsigned PROG_CNT_BITS   = 7;
endpackage

// File: core/spi_byte_rx.sv
// Serial shifter: samples link pins and delivers whole bytes
`timescale 1ns/100ps
`default_nettype none
module spi_byte_rx
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       cs_n_pin_i,
    input  wire logic       sck_pin_i,
    input  wire logic       si_pin_i,
    output logic            frame_start_o,
    output logic            frame_end_o,
    output logic            byte_valid_o,
    output logic [7:0]      byte_data_o,
    output logic            on_boundary_o
);
    typedef struct packed {
        logic [2:0] cs_n_sync;
        logic [2:0] sck_sync;
        logic [1:0] si_sync;
        logic [2:0] bit_cnt;
        logic [6:0] shift;
        logic       fstart;
        logic       fend;
        logic       bvalid;
        logic [7:0] bdata;
    } rx_state_s;

    rx_state_s st;
    rx_state_s next_st;

    always_comb
    begin
        next_st = st;
        next_st.fstart = 1'b0;
        next_st.fend = 1'b0;
        next_st.bvalid = 1'b0;
        next_st.cs_n_sync = {st.cs_n_sync[1:0], cs_n_pin_i};
        next_st.sck_sync = {st.sck_sync[1:0], sck_pin_i};
        next_st.si_sync = {st.si_sync[0], si_pin_i};
        if (st.cs_n_sync[2] && !st.cs_n_sync[1])
        begin
            next_st.fstart = 1'b1;
            next_st.bit_cnt = '0;
        end
        if (!st.cs_n_sync[2] && st.cs_n_sync[1])
        begin
            next_st.fend = 1'b1;
        end
        if (!st.cs_n_sync[1] && !st.sck_sync[2] && st.sck_sync[1])
        begin
            next_st.bit_cnt = st.bit_cnt + 3'h1;
            next_st.shift = {st.shift[5:0], st.si_sync[1]};
            if (st.bit_cnt == 3'h7)
            begin
                next_st.bvalid = 1'b1;
                next_st.bdata = {st.shift, st.si_sync[1]};
            end
        end
        if (rst_i)
        begin
            next_st = '0;
            next_st.cs_n_sync = 3'h7;
        end
    end

    always_ff @(posedge clk_i)
    begin
        st <= next_st;
    end

    assign frame_start_o = st.fstart;
    assign frame_end_o = st.fend;
    assign byte_valid_o = st.bvalid;
    assign byte_data_o = st.bdata;
    assign on_boundary_o = (st.bit_cnt == 3'h0);
endmodule
`default_nettype wire

// File: dv/wlatch_checker_assertions.sv
// Port-level assertions for the write latch and block lock block
`timescale 1ns/100ps
`default_nettype none
module wlatch_checker
(
    input wire logic         SYS_CLK_I,
    input wire logic         RST_I,
    input wire logic         CS_N_I,
    input wire logic         WRITE_LATCH_FLAG_O,
    input wire logic         PROGRAM_ERROR_FLAG_O,
    input wire logic         BUSY_FLAG_O,
    input wire logic         STATUS_WRITE_GO_O,
    input wire logic         GUARDED_GO_O,
    input wire logic         PROGRAM_START_O,
    input wire logic [255:0] BLOCK_LOCK_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    // Latch moves only after a frame ends, or when a program finishes
    property p_latch_cs;
        $changed(WRITE_LATCH_FLAG_O) && !$fell(BUSY_FLAG_O) |-> $past(CS_N_I, 3);
    endproperty
    a_latch_cs: assert property (p_latch_cs) else $error("latch moved in frame");
    property p_start_latch;
        PROGRAM_START_O |-> $past(WRITE_LATCH_FLAG_O);
    endproperty
    a_start_latch: assert property (p_start_latch) else $error("program w/o latch");
    property p_go_latch;
        GUARDED_GO_O |-> $past(WRITE_LATCH_FLAG_O);
    endproperty
    a_go_latch: assert property (p_go_latch) else $error("guarded go w/o latch");
    property p_stat_latch;
        STATUS_WRITE_GO_O |-> $past(WRITE_LATCH_FLAG_O);
    endproperty
    a_stat_latch: assert property (p_stat_latch) else $error("status go w/o latch");
    property p_busy_run;
        PROGRAM_START_O |-> ##[0:1] BUSY_FLAG_O [*8];
    endproperty
    a_busy_run: assert property (p_busy_run) else $error("busy not held");
    property p_busy_end;
        $fell(BUSY_FLAG_O) |-> !WRITE_LATCH_FLAG_O;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("latch set after program");
    property p_err_sticky;
        PROGRAM_ERROR_FLAG_O |=> PROGRAM_ERROR_FLAG_O;
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped");
    property p_lock_init;
        $fell(RST_I) |-> &BLOCK_LOCK_O;
    endproperty
    a_lock_init: assert property (p_lock_init) else $error("locks not set");
endmodule
bind write_latch_and_block_lock wlatch_checker wlatch_checker_i
(
    .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .CS_N_I(CS_N_I),
    .WRITE_LATCH_FLAG_O(WRITE_LATCH_FLAG_O), .PROGRAM_ERROR_FLAG_O(PROGRAM_ERROR_FLAG_O),
    .BUSY_FLAG_O(BUSY_FLAG_O), .STATUS_WRITE_GO_O(STATUS_WRITE_GO_O),
    .GUARDED_GO_O(GUARDED_GO_O), .PROGRAM_START_O(PROGRAM_START_O),
    .BLOCK_LOCK_O(BLOCK_LOCK_O)
);
`default_nettype wire

// File: dv/spi_host.sv
// Behavioural serial host driving chip select, clock and data
`timescale 1ns/100ps
`default_nettype none
module spi_host
(
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o
);
    initial
    begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end
    task automatic send(input logic [31:0] bits, input int n);
        cs_n_o = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            si_o = bits[31 - i];
            #160 sck_o = 1'b1;
            #160 sck_o = 1'b0;
        end
        #160 cs_n_o = 1'b1;
        si_o = ~si_o;
        #800;
    endtask
endmodule
`default_nettype wire

// File: dv/tb_write_latch_and_block_lock.sv
// Self-checking bench for the write latch and block lock block
`timescale 1ns/100ps
`default_nettype none
module tb_write_latch_and_block_lock;
    logic clk, rst, cs_n, sck, si, sel, fail, cmp_bit, size_bit, top_bot;
    logic [2:0] bp_field;
    logic [7:0] g_op;
    logic latch, err, busy, vol, st_go, st_vol, g_go, start, st_vol_seen;
    logic [15:0] page, page_seen;
    logic [255:0] locks;
    int n_fail = 0;
    int num_checks = 0;
    int n_start = 0;
    int n_go = 0;
    int n_st = 0;
    int cyc = 0;
    spi_host spi_host_i (.cs_n_o(cs_n), .sck_o(sck), .si_o(si));
    write_latch_and_block_lock write_latch_and_block_lock_i
    (
        .SYS_CLK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .SCK_I(sck), .SI_I(si),
        .PROTECT_SELECT_FLAG_I(sel), .PROTECT_COMPLEMENT_BIT_I(cmp_bit),
        .PROTECT_SIZE_BIT_I(size_bit), .TOP_BOTTOM_BIT_I(top_bot),
        .BLOCK_PROTECT_FIELD_I(bp_field),
        .PROGRAM_FAIL_I(fail), .WRITE_LATCH_FLAG_O(latch), .PROGRAM_ERROR_FLAG_O(err),
        .BUSY_FLAG_O(busy), .VOLATILE_WRITE_EN_O(vol), .STATUS_WRITE_GO_O(st_go),
        .STATUS_WRITE_VOLATILE_O(st_vol), .GUARDED_GO_O(g_go), .GUARDED_OPCODE_O(g_op),
        .PROGRAM_START_O(start), .PROGRAM_PAGE_O(page), .BLOCK_LOCK_O(locks)
    );
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [255:0] seen, input logic [255:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Pulse monitor and hang guard, sampling mid-cycle where pulses stand
    always @(negedge clk)
    begin
        cyc++;
        if (start === 1'b1)
        begin
            n_start++;
            page_seen = page;
        end
        if (g_go === 1'b1)
            n_go++;
        if (st_go === 1'b1)
        begin
            n_st++;
            st_vol_seen = st_vol;
        end
        if (cyc == 30000)
        begin
            n_fail++;
            results();
        end
    end
    task automatic cmd(input logic [31:0] v, input int n);
        @(posedge clk);
        #1;
        spi_host_i.send(v, n);
    endtask
    task automatic t_latch();
        check("locks_init", locks, {256{1'b1}});
        check("latch_init", latch, 1'b0);
        cmd({8'h06, 24'h0}, 13);
        check("latch_abort", latch, 1'b0);
        cmd({wlatch_pkg::OP_WRITE_ENABLE, 24'h0}, 8);
        check("latch_set", latch, 1'b1);
        cmd({8'h04, 24'h0}, 7);
        check("latch_keep", latch, 1'b1);
        cmd({wlatch_pkg::OP_WRITE_DISABLE, 24'h0}, 8);
        check("latch_clr", latch, 1'b0);
    endtask
    task automatic t_vol();
        int n;
        int g;
        n = n_st;
        g = n_go;
        cmd({8'h06, 24'h0}, 8);
        cmd({wlatch_pkg::OP_VOL_ENABLE, 24'h0}, 8);
        check("vol_latch", latch, 1'b1);
        check("vol_en", vol, 1'b1);
        cmd({wlatch_pkg::OP_STATUS_WR1, 24'h0}, 16);
        check("st_go", n_st, n + 1);
        check("st_vol", st_vol_seen, 1'b1);
        check("go_st", n_go, g + 1);
        check("g_op", g_op, wlatch_pkg::OP_STATUS_WR1);
        check("vol_lapse", vol, 1'b0);
        cmd({8'h06, 24'h0}, 8);
        cmd({wlatch_pkg::OP_STATUS_WR1, 24'h0}, 16);
        check("st_nonvol", st_vol_seen, 1'b0);
    endtask
    task automatic t_refuse();
        logic [7:0] ops [19] = '{8'h02, 8'ha2, 8'h32, 8'haf, 8'had, 8'h88, 8'h81,
            8'hdb, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h9b, 8'h01, 8'h31, 8'h11,
            8'h71, 8'h0a};
        int g, s, p;
        cmd({8'h04, 24'h0}, 8);
        g = n_go;
        s = n_st;
        p = n_start;
        foreach (ops[i])
            cmd({ops[i], 24'h0}, 32);
        cmd({wlatch_pkg::OP_BLOCK_LOCK, 24'h001000}, 32);
        check("go_none", n_go, g);
        check("st_none", n_st, s);
        check("start_none", n_start, p);
        check("lock_refused", locks, {256{1'b1}});
        cmd({8'h06, 24'h0}, 8);
        cmd({wlatch_pkg::OP_BLOCK_LOCK, 24'h0a5fff}, 32);
        check("lock_latch", latch, 1'b0);
        check("lock_bits", locks, {256{1'b1}});
    endtask
    task automatic t_prog();
        int p;
        p = n_start;
        sel = 1'b1;
        cmd({8'h06, 24'h0}, 8);
        cmd({wlatch_pkg::OP_BUF_PROGRAM, 24'h123456}, 32);
        check("prot_latch", latch, 1'b0);
        check("prot_start", n_start, p);
        sel = 1'b0;
        size_bit = 1'b1;
        top_bot = 1'b1;
        bp_field = 3'h7;
        cmd({8'h06, 24'h0}, 8);
        cmd({wlatch_pkg::OP_BUF_PROGRAM, 24'h123456}, 32);
        check("range_latch", latch, 1'b0);
        check("range_start", n_start, p);
        size_bit = 1'b0;
        top_bot = 1'b0;
        bp_field = 3'h0;
        cmp_bit = 1'b1;
        cmd({8'h06, 24'h0}, 8);
        cmd({wlatch_pkg::OP_BUF_PROGRAM, 24'h123456}, 32);
        check("cmp_latch", latch, 1'b0);
        check("cmp_start", n_start, p);
        cmp_bit = 1'b0;
        cmd({8'h06, 24'h0}, 8);
        cmd({wlatch_pkg::OP_BUF_PROGRAM, 24'h123456}, 24);
        check("short_latch", latch, 1'b0);
        check("short_start", n_start, p);
        fail = 1'b1;
        cmd({8'h06, 24'h0}, 8);
        cmd({wlatch_pkg::OP_BUF_PROGRAM, 24'h123456}, 32);
        check("start", n_start, p + 1);
        check("page", page_seen, 16'h1234);
        check("busy", busy, 1'b1);
        for (int i = 0; i < 200 && busy !== 1'b0; i++)
            #40;
        check("busy_done", busy, 1'b0);
        check("done_latch", latch, 1'b0);
        check("error", err, 1'b1);
        fail = 1'b0;
    endtask
    initial
    begin
        rst = 1'b1;
        sel = 1'b0;
        fail = 1'b0;
        cmp_bit = 1'b0;
        size_bit = 1'b0;
        top_bot = 1'b0;
        bp_field = 3'h0;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        t_latch();
        t_vol();
        t_refuse();
        t_prog();
        results();
    end
endmodule
`default_nettype wire
